// >>> logic/mvi_video_ctrl.sv
// microdisplay video input control: serial registers, gamma template, sync front end
// Function
// R1: each lane's 16-bit skew setting maps to zero up to fifteen delay units
// R2: read-only 7-bit lane skew check, all ones means timing is fine
// R3: frame pin role: embedded timing, frame enable, or vertical sync
// R4: line pin role: alignment only, or horizontal sync plus alignment
// R5: gamma template address advances by one on each low-byte access
// R6: upper two entry bits use their own register, no address advance
// R7: update trigger copies template into chosen colour tables, then self-clears
// R8: colour mask picks red, green, blue tables; red is msb; resets all set
// R9: read-only 3-bit backplane revision field
// R10: write-protect bit makes every other register read-only
// R11: enable level select; active enable scans, inactive holds last frame
// R12: non-stereo interlaced: active enable means odd field, field bit inverts
// R13: sync polarity bits pick rising or falling active edge, reset to rising
// R14: enable captured on vertical sync falling edge, governs the next frame
// R15: display-off resets to one; host must clear it to show an image
// R16: stereo frame mode forces progressive scan
// R17: scan type: 00 progressive, 01 interlaced, 1x pseudo-interlaced
// R18: source sends 240 to 512 active rows per interlaced field
// R19: vertical and horizontal scan direction bits
// R20: left-edge register, reset 0C, first active column of the window
// R21: host keeps left plus right edge constant when moving the window
// R22: stereo pair uses opposite enable levels tied to one stereo sync
// R23: right-edge register at 04h, reset 0C, last active column
// R24: host writes upper gamma bits before the low byte
// R25: polarity, scan and window settings take effect at a frame boundary
`timescale 1ns/100ps
module mvi_video_ctrl #(
	parameter logic [6:0] DEV_ADDR = 7'h30,
	parameter logic [2:0] SILICON_REV = 3'h0, // arbitrary value
	parameter int LANES = 7,
	parameter int GDEPTH = 256
) (
	// system
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// serial host port
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	// lane skew
	input wire logic [LANES-1:0] lane_skew_ok_in,
	output logic [LANES-1:0][3:0] lane_delay_out,
	// gamma colour tables
	output logic [2:0] gamma_wr_en_out,
	output logic [7:0] gamma_wr_addr_out,
	output logic [9:0] gamma_wr_data_out,
	// video link
	input wire logic vid_clk_in,
	input wire logic frame_pin_in,
	input wire logic line_pin_in,
	input wire logic emb_vsync_in,
	input wire logic emb_hsync_in,
	output logic frame_start_out,
	output logic line_start_out,
	output logic align_out,
	output logic scan_enable_out,
	output logic field_odd_out,
	output logic [1:0] scan_type_out,
	output logic vert_dir_out,
	output logic horiz_dir_out,
	output logic display_off_out,
	output logic [7:0] left_edge_out,
	output logic [7:0] right_edge_out
);
	import mvi_pkg::*;

	// ==========================================================
	// decode helpers
	function automatic logic is_skew(input logic [7:0] a);
		return (a >= ADR_SKEW_FIRST) && (a <= ADR_SKEW_LAST);
	endfunction

	function automatic logic [2:0] skew_lane(input logic [7:0] a);
		logic [7:0] d;
		d = a - ADR_SKEW_FIRST;
		return d[3:1];
	endfunction

	function automatic logic [3:0] lane_units(input logic [15:0] v);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 0; i < 16; i++)
			n = n + 5'(v[i]);
		return (n > 5'h0F) ? 4'hF : n[3:0];
	endfunction

	// ==========================================================
	// pin synchronisers
	logic [2:0] scl_s;
	logic [2:0] sda_s;
	logic scl_f;
	logic sda_f;
	logic scl_p;
	logic sda_p;
	logic [2:0][LANES-1:0] sk_s;
	logic [LANES-1:0] sk_flags;

	always_ff @(posedge mclk_in)
	begin
		scl_s <= {scl_s[1:0], scl_in};
		sda_s <= {sda_s[1:0], sda_in};
		sk_s <= {sk_s[1:0], lane_skew_ok_in};
		if (!rst_n_in)
		begin
			scl_f <= 1'b1;
			sda_f <= 1'b1;
			scl_p <= 1'b1;
			sda_p <= 1'b1;
			sk_flags <= '0;
		end
		else
		begin
			if (scl_s[2] == scl_s[1])
				scl_f <= scl_s[2];
			if (sda_s[2] == sda_s[1])
				sda_f <= sda_s[2];
			scl_p <= scl_f;
			sda_p <= sda_f;
			for (int i = 0; i < LANES; i++)
				if (sk_s[2][i] == sk_s[1][i])
					sk_flags[i] <= sk_s[2][i]; // R2
		end
	end

	wire scl_rise = scl_f && !scl_p;
	wire scl_fall = !scl_f && scl_p;
	wire bus_start = scl_f && scl_p && sda_p && !sda_f;
	wire bus_stop = scl_f && scl_p && !sda_p && sda_f;

	// ==========================================================
	// serial host slave
	mvi_i2c_t ist;
	logic [3:0] bcnt;
	logic [7:0] shreg;
	logic [7:0] txreg;
	logic [7:0] ptr;
	logic rw;
	logic wr_stb;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic rd_stb;
	logic [7:0] rd_addr;
	logic [7:0] rd_val;

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			ist <= I2C_IDLE;
			bcnt <= 4'h0;
			shreg <= 8'h00;
			txreg <= 8'h00;
			ptr <= 8'h00;
			rw <= 1'b0;
			wr_stb <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
			rd_stb <= 1'b0;
			rd_addr <= 8'h00;
			sda_oe_n_out <= 1'b1;
		end
		else
		begin
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
			if (bus_start)
			begin
				ist <= I2C_ADDR;
				bcnt <= 4'h0;
				sda_oe_n_out <= 1'b1;
			end
			else if (bus_stop)
			begin
				ist <= I2C_IDLE;
				sda_oe_n_out <= 1'b1;
			end
			else if (scl_rise)
			begin
				if (ist == I2C_RACK)
				begin
					if (sda_f)
						ist <= I2C_IDLE;
				end
				else
				begin
					shreg <= {shreg[6:0], sda_f};
					bcnt <= bcnt + 4'h1;
				end
			end
			else if (scl_fall)
			begin
				case (ist)
					I2C_ADDR:
						if (bcnt == 4'h8)
						begin
							if (shreg[7:1] == DEV_ADDR)
							begin
								rw <= shreg[0];
								sda_oe_n_out <= 1'b0;
								ist <= I2C_AACK;
							end
							else
								ist <= I2C_IDLE;
						end
					I2C_PTR:
						if (bcnt == 4'h8)
						begin
							ptr <= shreg;
							sda_oe_n_out <= 1'b0;
							ist <= I2C_PACK;
						end
					I2C_WR:
						if (bcnt == 4'h8)
						begin
							wr_stb <= 1'b1;
							wr_addr <= ptr;
							wr_data <= shreg;
							ptr <= ptr + 8'h01;
							sda_oe_n_out <= 1'b0;
							ist <= I2C_WACK;
						end
					I2C_PACK, I2C_WACK:
					begin
						sda_oe_n_out <= 1'b1;
						bcnt <= 4'h0;
						ist <= I2C_WR;
					end
					I2C_RD:
						if (bcnt == 4'h8)
						begin
							sda_oe_n_out <= 1'b1;
							ist <= I2C_RACK;
						end
						else
						begin
							sda_oe_n_out <= txreg[6];
							txreg <= {txreg[6:0], 1'b0};
						end
					I2C_AACK, I2C_RACK:
					begin
						bcnt <= 4'h0;
						if (ist == I2C_AACK && !rw)
						begin
							sda_oe_n_out <= 1'b1;
							ist <= I2C_PTR;
						end
						else
						begin
							// open-drain: a one releases the line
							txreg <= rd_val;
							sda_oe_n_out <= rd_val[7];
							rd_stb <= 1'b1;
							rd_addr <= ptr;
							ptr <= ptr + 8'h01;
							ist <= I2C_RD;
						end
					end
					default:
						ist <= I2C_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge mclk_in)
		sda_out <= 1'b0;

	// ==========================================================
	// settings registers
	logic [4:0] vin;
	logic [5:0] disp;
	logic [7:0] left_edge;
	logic [7:0] right_edge;
	logic [2:0] roles;
	logic [3:0] rsv_a;
	logic [4:0] rsv_b;
	logic [7:0] rsv_c;
	logic [15:0] skew [LANES];
	logic [7:0] gaddr;
	logic [9:0] tmpl [GDEPTH];
	logic [3:0] upd;

	wire wr_ok = wr_stb && (wr_addr == ADR_VIN || !vin[B_WP]); // R10

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			vin <= RST_VIN; // R13
			disp <= RST_DISP; // R15
			left_edge <= RST_EDGE; // R20
			right_edge <= RST_EDGE; // R23
			roles <= RST_ROLES;
			rsv_a <= 4'h0;
			rsv_b <= 5'h00;
			rsv_c <= 8'h00;
			for (int i = 0; i < LANES; i++)
				skew[i] <= 16'h0000;
		end
		else if (wr_ok)
		begin
			if (wr_addr == ADR_VIN)
				vin <= wr_data[4:0];
			else if (wr_addr == ADR_DISP)
				disp <= wr_data[5:0];
			else if (wr_addr == ADR_LEFT)
				left_edge <= wr_data;
			else if (wr_addr == ADR_RIGHT)
				right_edge <= wr_data;
			else if (wr_addr == ADR_ROLES)
				roles <= wr_data[2:0]; // R3 R4
			else if (wr_addr == ADR_RSVA)
				rsv_a <= wr_data[3:0];
			else if (wr_addr == ADR_RSVB)
				rsv_b <= wr_data[4:0];
			else if (wr_addr == ADR_RSVC)
				rsv_c <= wr_data;
			else if (is_skew(wr_addr) && int'(skew_lane(wr_addr)) < LANES)
			begin
				if (wr_addr[0])
					skew[skew_lane(wr_addr)][7:0] <= wr_data;
				else
					skew[skew_lane(wr_addr)][15:8] <= wr_data;
			end
		end
	end

	// gamma template table and its address
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			gaddr <= 8'h00;
		else if (wr_ok && wr_addr == ADR_GADR)
			gaddr <= wr_data;
		else if (wr_ok && wr_addr == ADR_GLO)
		begin
			tmpl[gaddr][7:0] <= wr_data;
			gaddr <= gaddr + 8'h01; // R5
		end
		else if (wr_ok && wr_addr == ADR_GHI)
			tmpl[gaddr][9:8] <= wr_data[1:0]; // R6
		else if (rd_stb && rd_addr == ADR_GLO)
			gaddr <= gaddr + 8'h01; // R5
	end

	always_comb
	begin
		rd_val = 8'h00;
		if (ptr == ADR_STAT)
			rd_val = {5'h00, SILICON_REV}; // R9
		else if (ptr == ADR_VIN)
			rd_val = {3'h0, vin};
		else if (ptr == ADR_DISP)
			rd_val = {2'h0, disp};
		else if (ptr == ADR_LEFT)
			rd_val = left_edge;
		else if (ptr == ADR_RIGHT)
			rd_val = right_edge;
		else if (ptr == ADR_SKCHK)
			rd_val = 8'(sk_flags); // R2
		else if (ptr == ADR_ROLES)
			rd_val = {5'h00, roles};
		else if (ptr == ADR_GADR)
			rd_val = gaddr;
		else if (ptr == ADR_GLO)
			rd_val = tmpl[gaddr][7:0];
		else if (ptr == ADR_GHI)
			rd_val = {6'h00, tmpl[gaddr][9:8]};
		else if (ptr == ADR_UPD)
			rd_val = {4'h0, upd};
		else if (ptr == ADR_RSVA)
			rd_val = {4'h0, rsv_a};
		else if (ptr == ADR_RSVB)
			rd_val = {3'h0, rsv_b};
		else if (ptr == ADR_RSVC)
			rd_val = rsv_c;
		else if (is_skew(ptr) && int'(skew_lane(ptr)) < LANES)
			rd_val = ptr[0] ? skew[skew_lane(ptr)][7:0] : skew[skew_lane(ptr)][15:8];
	end

	// ==========================================================
	// lane delay outputs
	for (genvar g = 0; g < LANES; g++)
	begin : g_lane
		always_ff @(posedge mclk_in)
		begin
			if (!rst_n_in)
				lane_delay_out[g] <= 4'h0;
			else
				lane_delay_out[g] <= lane_units(skew[g]); // R1
		end
	end

	// ==========================================================
	// gamma update copy
	mvi_copy_t cst;
	logic [7:0] cidx;
	logic [2:0] cmask;
	wire cp_done = (cst == CP_RUN) && (cidx == 8'(GDEPTH - 1));

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			upd <= RST_UPD; // R8
		else if (wr_ok && wr_addr == ADR_UPD)
			upd <= wr_data[3:0];
		else if (cp_done)
			upd[B_TRIG] <= 1'b0; // R7
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			cst <= CP_IDLE;
			cidx <= 8'h00;
			cmask <= 3'h0;
			gamma_wr_en_out <= 3'h0;
			gamma_wr_addr_out <= 8'h00;
			gamma_wr_data_out <= 10'h000;
		end
		else
		begin
			case (cst)
				CP_IDLE:
				begin
					gamma_wr_en_out <= 3'h0;
					cidx <= 8'h00;
					cmask <= upd[2:0];
					if (upd[B_TRIG])
						cst <= CP_RUN;
				end
				CP_RUN:
				begin
					gamma_wr_en_out <= cmask; // R8
					gamma_wr_addr_out <= cidx;
					gamma_wr_data_out <= tmpl[cidx]; // R7
					cidx <= cidx + 8'h01;
					if (cp_done)
						cst <= CP_IDLE;
				end
				default:
					cst <= CP_IDLE;
			endcase
		end
	end

	// ==========================================================
	// settings handshake to the link clock
	wire [CF_W-1:0] live = {right_edge, left_edge, roles, disp, vin};
	logic [CF_W-1:0] cfg_hold;
	logic req_t;
	logic ack_t;
	logic [2:0] ack_s;
	logic ack_f;

	always_ff @(posedge mclk_in)
	begin
		ack_s <= {ack_s[1:0], ack_t};
		if (!rst_n_in)
		begin
			ack_f <= 1'b0;
			req_t <= 1'b0;
			cfg_hold <= {RST_EDGE, RST_EDGE, RST_ROLES, RST_DISP, RST_VIN};
		end
		else
		begin
			if (ack_s[2] == ack_s[1])
				ack_f <= ack_s[2];
			if (ack_f == req_t && live != cfg_hold)
			begin
				cfg_hold <= live;
				req_t <= ~req_t;
			end
		end
	end

	// ==========================================================
	// link clock domain
	logic [2:0] lrs;
	logic [2:0] req_s;
	logic [2:0] fp_s;
	logic req_f;
	logic req_p;
	logic fp_f;
	logic [CF_W-1:0] pend;
	logic pend_v;
	logic [CF_W-1:0] lcfg;
	logic vs_p;
	logic hs_p;
	logic en_cap;
	wire lrst_n = lrs[2];
	wire req_evt = req_f != req_p;
	wire [CF_W-1:0] nc = pend_v ? pend : lcfg;
	wire [1:0] frole = lcfg[CF_ROLE+B_FROLE +: 2];
	wire vs = (frole == ROLE_VS) ? fp_f : emb_vsync_in; // R3
	wire hs = lcfg[CF_ROLE+B_LROLE] ? line_pin_in : emb_hsync_in; // R4
	wire vs_fall = vs_p && !vs;
	wire vs_edge = lcfg[CF_VIN+B_VPOL] ? (vs && !vs_p) : vs_fall; // R13
	wire hs_edge = lcfg[CF_VIN+B_HPOL] ? (hs && !hs_p) : (hs_p && !hs); // R13
	wire en_act = (frole == ROLE_EN) ? (fp_f == lcfg[CF_VIN+B_ENLVL]) : 1'b1; // R11
	wire nc_stereo = nc[CF_DISP+B_STEREO];
	wire [1:0] nc_scan = nc_stereo ? SCAN_PROG : nc[CF_DISP+B_SCAN +: 2]; // R16 R17

	always_ff @(posedge vid_clk_in)
	begin
		lrs <= {lrs[1:0], rst_n_in};
		req_s <= {req_s[1:0], req_t};
		fp_s <= {fp_s[1:0], frame_pin_in};
	end

	always_ff @(posedge vid_clk_in)
	begin
		if (!lrst_n)
		begin
			req_f <= 1'b0;
			req_p <= 1'b0;
			fp_f <= 1'b0;
			vs_p <= 1'b0;
			hs_p <= 1'b0;
			en_cap <= 1'b1;
			line_start_out <= 1'b0;
			align_out <= 1'b0;
		end
		else
		begin
			if (req_s[2] == req_s[1])
				req_f <= req_s[2];
			if (fp_s[2] == fp_s[1])
				fp_f <= fp_s[2];
			req_p <= req_f;
			vs_p <= vs;
			hs_p <= hs;
			if (vs_fall)
				en_cap <= en_act; // R14
			line_start_out <= hs_edge; // R4
			align_out <= line_pin_in;
		end
	end

	// pending settings wait for the next frame boundary
	always_ff @(posedge vid_clk_in)
	begin
		if (!lrst_n)
		begin
			pend <= {RST_EDGE, RST_EDGE, RST_ROLES, RST_DISP, RST_VIN};
			pend_v <= 1'b0;
			lcfg <= {RST_EDGE, RST_EDGE, RST_ROLES, RST_DISP, RST_VIN};
			ack_t <= 1'b0;
		end
		else
		begin
			if (vs_edge && pend_v)
				lcfg <= pend; // R25
			if (req_evt)
			begin
				pend <= cfg_hold;
				pend_v <= 1'b1;
				ack_t <= req_f;
			end
			else if (vs_edge)
				pend_v <= 1'b0;
		end
	end

	always_ff @(posedge vid_clk_in)
	begin
		if (!lrst_n)
		begin
			frame_start_out <= 1'b0;
			scan_enable_out <= 1'b0;
			field_odd_out <= 1'b1;
			scan_type_out <= SCAN_PROG;
			vert_dir_out <= 1'b0;
			horiz_dir_out <= 1'b0;
			display_off_out <= 1'b1; // R15
			left_edge_out <= RST_EDGE;
			right_edge_out <= RST_EDGE;
		end
		else
		begin
			frame_start_out <= vs_edge;
			if (vs_edge)
			begin
				scan_type_out <= nc_scan; // R16 R17
				scan_enable_out <= (!nc_stereo && nc_scan == SCAN_IL) || en_cap; // R11
				field_odd_out <= en_cap ^ nc[CF_VIN+B_FIELD]; // R12
				vert_dir_out <= nc[CF_DISP+B_VDIR]; // R19
				horiz_dir_out <= nc[CF_DISP+B_HDIR]; // R19
				display_off_out <= nc[CF_DISP+B_DOFF]; // R15
				left_edge_out <= nc[CF_LEFT +: 8]; // R20
				right_edge_out <= nc[CF_RIGHT +: 8]; // R23
			end
		end
	end

	// ==========================================================
	// checks
	sequence s_glo_read;
		rd_stb && rd_addr == ADR_GLO && !wr_ok;
	endsequence

	property p_wp_blocks;
		@(posedge mclk_in) disable iff (!rst_n_in)
		wr_stb && wr_addr == ADR_LEFT && vin[B_WP] |=> $stable(left_edge);
	endproperty
	a_wp_blocks: assert property (p_wp_blocks) else $error("protected write landed"); // R10

	property p_glo_adv;
		@(posedge mclk_in) disable iff (!rst_n_in)
		s_glo_read |=> gaddr == $past(gaddr) + 8'h01;
	endproperty
	a_glo_adv: assert property (p_glo_adv) else $error("gamma address did not advance"); // R5

	property p_ghi_hold;
		@(posedge mclk_in) disable iff (!rst_n_in)
		wr_ok && wr_addr == ADR_GHI |=> $stable(gaddr);
	endproperty
	a_ghi_hold: assert property (p_ghi_hold) else $error("high bits moved address"); // R6

	property p_trig_clear;
		@(posedge mclk_in) disable iff (!rst_n_in)
		cp_done && !(wr_ok && wr_addr == ADR_UPD) |=> !upd[B_TRIG] ##1 gamma_wr_en_out == 3'h0;
	endproperty
	a_trig_clear: assert property (p_trig_clear) else $error("trigger not cleared"); // R7

	property p_colour;
		@(posedge mclk_in) disable iff (!rst_n_in)
		$rose(upd[B_TRIG]) && cst == CP_IDLE |-> ##2 gamma_wr_en_out == $past(upd[2:0], 2);
	endproperty
	a_colour: assert property (p_colour) else $error("wrong colour tables"); // R8

	property p_delay;
		@(posedge mclk_in) disable iff (!rst_n_in)
		skew[0] == 16'hFFFF |=> lane_delay_out[0] == 4'hF;
	endproperty
	a_delay: assert property (p_delay) else $error("lane delay wrong"); // R1

	property p_en_cap;
		@(posedge vid_clk_in) disable iff (!lrst_n)
		vs_fall |=> en_cap == $past(en_act);
	endproperty
	a_en_cap: assert property (p_en_cap) else $error("enable not captured"); // R14

	property p_stereo_prog;
		@(posedge vid_clk_in) disable iff (!lrst_n)
		vs_edge && nc_stereo |=> scan_type_out == SCAN_PROG && frame_start_out;
	endproperty
	a_stereo_prog: assert property (p_stereo_prog) else $error("stereo not progressive"); // R16

	property p_frame_hold;
		@(posedge vid_clk_in) disable iff (!lrst_n)
		!vs_edge |=> $stable(left_edge_out) && $stable(display_off_out);
	endproperty
	a_frame_hold: assert property (p_frame_hold) else $error("settings changed mid-frame"); // R25
endmodule

// >>> logic/mvi_pkg.sv
// constants and types for the microdisplay video input control block
package mvi_pkg;
	// register offsets
	localparam logic [7:0] ADR_STAT = 8'h00;
	localparam logic [7:0] ADR_VIN = 8'h01;
	localparam logic [7:0] ADR_DISP = 8'h02;
	localparam logic [7:0] ADR_LEFT = 8'h03;
	localparam logic [7:0] ADR_RIGHT = 8'h04;
	localparam logic [7:0] ADR_SKEW_FIRST = 8'h22;
	localparam logic [7:0] ADR_SKEW_LAST = 8'h2F;
	localparam logic [7:0] ADR_SKCHK = 8'h31;
	localparam logic [7:0] ADR_ROLES = 8'h32;
	localparam logic [7:0] ADR_GADR = 8'h33;
	localparam logic [7:0] ADR_GLO = 8'h34;
	localparam logic [7:0] ADR_GHI = 8'h35;
	localparam logic [7:0] ADR_UPD = 8'h36;
	localparam logic [7:0] ADR_RSVA = 8'h37;
	localparam logic [7:0] ADR_RSVB = 8'h38;
	localparam logic [7:0] ADR_RSVC = 8'h39;
	// field positions
	localparam int B_WP = 4;
	localparam int B_ENLVL = 3;
	localparam int B_FIELD = 2;
	localparam int B_VPOL = 1;
	localparam int B_HPOL = 0;
	localparam int B_DOFF = 5;
	localparam int B_STEREO = 4;
	localparam int B_SCAN = 2;
	localparam int B_VDIR = 1;
	localparam int B_HDIR = 0;
	localparam int B_TRIG = 3;
	localparam int B_FROLE = 1;
	localparam int B_LROLE = 0;
	// reset values
	localparam logic [4:0] RST_VIN = 5'h03;
	localparam logic [5:0] RST_DISP = 6'h20;
	localparam logic [7:0] RST_EDGE = 8'h0C;
	localparam logic [2:0] RST_ROLES = 3'h2;
	localparam logic [3:0] RST_UPD = 4'h7;
	// pin roles and scan codes
	localparam logic [1:0] ROLE_EMB = 2'h0;
	localparam logic [1:0] ROLE_EN = 2'h1;
	localparam logic [1:0] ROLE_VS = 2'h2;
	localparam logic [1:0] SCAN_PROG = 2'h0;
	localparam logic [1:0] SCAN_IL = 2'h1;
	// layout of the settings word that crosses to the link clock
	localparam int CF_VIN = 0;
	localparam int CF_DISP = 5;
	localparam int CF_ROLE = 11;
	localparam int CF_LEFT = 14;
	localparam int CF_RIGHT = 22;
	localparam int CF_W = 30;
	typedef enum logic [8:0] {
		I2C_IDLE = 9'h001, I2C_ADDR = 9'h002, I2C_AACK = 9'h004,
		I2C_PTR = 9'h008, I2C_PACK = 9'h010, I2C_WR = 9'h020,
		I2C_WACK = 9'h040, I2C_RD = 9'h080, I2C_RACK = 9'h100
	} mvi_i2c_t;
	typedef enum logic [1:0] {
		CP_IDLE = 2'h1, CP_RUN = 2'h2
	} mvi_copy_t;
endpackage

// >>> verif/mvi_video_src.sv
// video source model: free-running frames of sync pulses
`timescale 1ns/100ps
module mvi_video_src #(
	parameter int ROWS = 240
) (
	input wire logic vid_clk_in,
	input wire logic go_in,
	output logic vsync_out,
	output logic hsync_out
);
	int cnt = 0;
	// ==========
	// 8-cycle vertical pulse, then ROWS line pulses
	always @(posedge vid_clk_in)
	begin
		cnt <= (!go_in || cnt == (ROWS + 2) * 4 - 1) ? 0 : cnt + 1;
	end
	assign vsync_out = go_in && cnt < 8;
	assign hsync_out = cnt >= 8 && cnt[1:0] == 2'h0;
endmodule

// >>> verif/tb_mvi_video_ctrl.sv
// self-checking bench for the video input control block
`timescale 1ns/100ps
module tb_mvi_video_ctrl;
	import mvi_pkg::*;
	logic mclk_in = 0;
	logic vclk = 0;
	logic rst_n = 0;
	logic scl = 1;
	logic sda_tb = 1;
	logic go = 0;
	logic en_pin = 0;
	logic alt = 0;
	logic ls, al;
	int n_line = 0;
	int n_al = 0;
	int n_fs = 0;
	logic [6:0] skew_ok = 7'h5A;
	logic sda_o, sda_oe_n, fs, vs, hs, scan_en, odd, vdir, hdir, doff;
	logic [6:0][3:0] dly;
	logic [2:0] g_en, c_en;
	logic [7:0] g_adr, left, right;
	logic [9:0] g_dat, c_dat;
	logic [1:0] scan_t;
	int err_count = 0;
	int checked = 0;
	int n_copy = 0;
	wire sda = sda_tb & (sda_oe_n | sda_o);
	// alt: vertical sync also drives the frame pin, horizontal sync leaves the embedded input
	wire fpin = alt ? vs : en_pin;
	wire ehs = hs & !alt;
	// ==========
	// clocks, design, source
	initial forever #5 mclk_in = ~mclk_in;
	initial
	begin
		#2.3;
		forever #3 vclk = ~vclk;
	end
	mvi_video_ctrl #(
		.DEV_ADDR(7'h30)
	) mvi_video_ctrl_i (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(sda_o),
		.sda_oe_n_out(sda_oe_n),
		.lane_skew_ok_in(skew_ok),
		.lane_delay_out(dly),
		.gamma_wr_en_out(g_en),
		.gamma_wr_addr_out(g_adr),
		.gamma_wr_data_out(g_dat),
		.vid_clk_in(vclk),
		.frame_pin_in(fpin),
		.line_pin_in(hs),
		.emb_vsync_in(vs),
		.emb_hsync_in(ehs),
		.frame_start_out(fs),
		.line_start_out(ls),
		.align_out(al),
		.scan_enable_out(scan_en),
		.field_odd_out(odd),
		.scan_type_out(scan_t),
		.vert_dir_out(vdir),
		.horiz_dir_out(hdir),
		.display_off_out(doff),
		.left_edge_out(left),
		.right_edge_out(right)
	);
	mvi_video_src mvi_video_src_i (
		.vid_clk_in(vclk),
		.go_in(go),
		.vsync_out(vs),
		.hsync_out(hs)
	);
	// first entry of each table copy
	always @(posedge mclk_in)
		if (rst_n === 1'b1 && g_en !== 3'h0)
		begin
			n_copy++;
			if (g_adr === 8'h00)
				{c_en, c_dat} = {g_en, g_dat};
		end
	// line, align and frame pulse counts
	always @(posedge vclk)
	begin
		n_line += int'(ls === 1'b1);
		n_al += int'(al === 1'b1);
		n_fs += int'(fs === 1'b1);
	end
	// ==========
	// helpers
	task automatic check(input string nm, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic half;
		repeat (8) @(posedge mclk_in);
		#1;
	endtask
	task automatic start;
		scl = 0;
		half;
		sda_tb = 1;
		half;
		scl = 1;
		half;
		sda_tb = 0;
		half;
	endtask
	task automatic stop;
		scl = 0;
		half;
		sda_tb = 0;
		half;
		scl = 1;
		half;
		sda_tb = 1;
		half;
	endtask
	task automatic bit_io(input logic b, output logic r);
		scl = 0;
		half;
		sda_tb = b;
		half;
		scl = 1;
		half;
		r = sda;
	endtask
	// data FF doubles as a read with master nack
	task automatic xfer(input logic [7:0] d, output logic [7:0] r);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(1'b1, a);
		if (d !== 8'hFF)
			check("ack", a, 1'b0);
	endtask
	task automatic wr(input logic [7:0] adr, dat);
		logic [7:0] r;
		start;
		xfer(8'h60, r);
		xfer(adr, r);
		xfer(dat, r);
		stop;
	endtask
	task automatic rc(input logic [7:0] adr, exp);
		logic [7:0] r;
		start;
		xfer(8'h60, r);
		xfer(adr, r);
		start;
		xfer(8'h61, r);
		xfer(8'hFF, r);
		stop;
		check("register", r, exp);
	endtask
	task automatic frames(input int n);
		int k;
		repeat (n)
		begin
			k = 0;
			while (fs !== 1'b1 && k < 3000)
			begin
				@(posedge vclk);
				#1;
				k++;
			end
			check("frame", k < 3000, 1'b1);
			@(posedge vclk);
			#1;
		end
	endtask
	// ==========
	// scenarios
	task automatic t_regs;
		rc(ADR_STAT, 8'h00);
		rc(ADR_VIN, 8'h03);
		rc(ADR_DISP, 8'h20);
		rc(ADR_LEFT, 8'h0C);
		rc(ADR_RIGHT, 8'h0C);
		rc(ADR_ROLES, 8'h02);
		rc(ADR_UPD, 8'h07);
		rc(ADR_SKCHK, 8'h5A);
		rc(8'h50, 8'h00);
	endtask
	task automatic t_protect;
		wr(ADR_VIN, 8'h13);
		wr(ADR_LEFT, 8'h20);
		rc(ADR_LEFT, 8'h0C);
		rc(ADR_VIN, 8'h13);
		wr(ADR_VIN, 8'h03);
		wr(ADR_LEFT, 8'h10);
		wr(ADR_RIGHT, 8'h08);
		rc(ADR_LEFT, 8'h10);
	endtask
	task automatic t_gamma;
		wr(ADR_GHI, 8'h02);
		rc(ADR_GADR, 8'h00);
		wr(ADR_GLO, 8'h55);
		rc(ADR_GADR, 8'h01);
		wr(ADR_GADR, 8'h00);
		rc(ADR_GHI, 8'h02);
		rc(ADR_GLO, 8'h55);
		rc(ADR_GADR, 8'h01);
		wr(ADR_UPD, 8'h0C);
		repeat (400) @(posedge mclk_in);
		check("copies", 16'(n_copy), 16'd256);
		check("colour", c_en, 3'h4);
		check("entry", c_dat, 10'h255);
		rc(ADR_UPD, 8'h04);
		wr(8'h22, 8'hFF);
		wr(8'h23, 8'hFF);
		wr(8'h25, 8'h01);
		check("lane0", dly[0], 4'hF);
		check("lane1", dly[1], 4'h1);
		check("lane2", dly[2], 4'h0);
	endtask
	task automatic t_video;
		wr(ADR_DISP, 8'h03);
		frames(2);
		check("off", doff, 1'b0);
		check("dirs", {vdir, hdir}, 2'h3);
		check("left", left, 8'h10);
		check("right", right, 8'h08);
		check("scan", scan_en, 1'b1);
		en_pin = 1;
		frames(2);
		check("hold", scan_en, 1'b0);
		wr(ADR_VIN, 8'h0B);
		frames(2);
		check("scan", scan_en, 1'b1);
		wr(ADR_DISP, 8'h04);
		frames(2);
		check("il", scan_t, 2'h1);
		check("odd", odd, 1'b1);
		wr(ADR_VIN, 8'h0F);
		frames(2);
		check("even", odd, 1'b0);
		wr(ADR_DISP, 8'h14);
		frames(2);
		check("stereo", scan_t, 2'h0);
		wr(ADR_DISP, 8'h08);
		frames(2);
		check("pseudo", scan_t, 2'h2);
	endtask
	task automatic t_lines;
		int l0;
		int a0;
		frames(1);
		check("vpol", vs, 1'b1);
		l0 = n_line;
		a0 = n_al;
		frames(1);
		check("lines", 16'(n_line - l0), 16'd240);
		check("align", 16'(n_al - a0), 16'd240);
		alt = 1;
		wr(ADR_ROLES, 8'h05);
		frames(2);
		l0 = n_line;
		frames(1);
		check("pin lines", 16'(n_line - l0), 16'd240);
		alt = 0;
		l0 = n_fs;
		repeat (1200) @(posedge vclk);
		check("pin frames", 16'(n_fs - l0), 16'd0);
		alt = 1;
		wr(ADR_ROLES, 8'h02);
		frames(2);
		alt = 0;
		wr(ADR_VIN, 8'h0D);
		frames(2);
		check("vpol", vs, 1'b0);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==========
	// main sequence and watchdog
	initial
	begin
		#1000000;
		err_count++;
		finish_test;
	end
	initial
	begin
		repeat (8) @(posedge mclk_in);
		#1;
		rst_n = 1;
		go = 1;
		half;
		check("dark", doff, 1'b1);
		t_regs;
		t_protect;
		t_gamma;
		t_video;
		t_lines;
		finish_test;
	end
endmodule
